// *** hdl/idc_cond_eval.sv ***
`timescale 1ns/1ns
`include "idc_defs.svh"

// branch condition and bit-test skip evaluation, purely combinational
module idc_cond_eval (
  input wire logic [2:0] cond_in,
  input wire logic zero_in,
  input wire logic carry_in,
  input wire logic ovf_in,
  input wire logic neg_in,
  input wire logic test_bit_in,
  input wire logic skip_on_set_in,
  output logic branch_ok_out,
  output logic skip_ok_out
);

  logic flag_sel;

  // cond[0] inverts the selected flag
  always_comb begin
    case (cond_in[2:1])
      `IDC_CC_ZERO: flag_sel = zero_in;
      `IDC_CC_CARRY: flag_sel = carry_in;
      `IDC_CC_OVF: flag_sel = ovf_in;
      `IDC_CC_NEG: flag_sel = neg_in;
      default: flag_sel = 1'b0;
    endcase
    branch_ok_out = flag_sel ^ cond_in[0];
    skip_ok_out = skip_on_set_in ? test_bit_in : ~test_bit_in;
  end

endmodule : idc_cond_eval

// *** hdl/idc_decoder.sv ***
`timescale 1ns/1ns
`include "idc_defs.svh"

// Function
// - bit clear/set/toggle: one cycle, no flags
// - bit test skip: one, two or three cycles
// - conditional branch on eight flag conditions
// - absolute call: two words, two cycles
// - absolute jump, relative jump and call
// - interrupt and subroutine returns, fast restore
// - literal return loads working register
// - stack push and pop, one cycle
// - standby, watchdog clear, software reset
// - literal add updates all five flags
// - literal subtract updates all five flags
// - literal and/or/xor update zero, negative
// - literal multiply and move, no flags
// - four-bit literal into bank select
// - two-word twelve-bit pointer literal load
// - table read with four pointer modes
// - table write with four pointer modes
// - port read-modify-write uses pin level
// - bit write to timer zero clears prescaler when the prescaler is assigned to timer zero
// - taken branch, relative transfer or return adds a nop cycle
// - stray second-word prefix executes as nop
module idc_decoder (
  input wire logic sys_clk_in,
  input wire logic rst_n_in,
  input wire logic clk_en_in,
  input wire logic [15:0] instr_in,
  input wire logic carry_in,
  input wire logic zero_in,
  input wire logic ovf_in,
  input wire logic neg_in,
  input wire logic test_bit_in,
  input wire logic target_is_port_in,
  input wire logic target_is_timer_zero_in,
  input wire logic prescaler_on_timer_zero_in,
  output logic [3:0] alu_op_out,
  output logic [7:0] literal_out,
  output logic wreg_write_out,
  output logic [4:0] flag_upd_out,
  output logic [7:0] file_addr_out,
  output logic [2:0] bit_pos_out,
  output logic access_sel_out,
  output logic file_write_out,
  output logic use_pin_level_out,
  output logic prescaler_clear_out,
  output logic skip_out,
  output logic branch_taken_out,
  output logic pc_load_out,
  output logic pc_rel_out,
  output logic [19:0] pc_target_out,
  output logic [10:0] pc_offset_out,
  output logic stack_push_out,
  output logic stack_pop_out,
  output logic fast_save_out,
  output logic fast_restore_out,
  output logic gie_enable_out,
  output logic standby_out,
  output logic wdt_clear_out,
  output logic soft_reset_out,
  output logic bank_load_out,
  output logic ptr_load_out,
  output logic [1:0] ptr_sel_out,
  output logic [11:0] ptr_value_out,
  output logic tbl_read_out,
  output logic tbl_write_out,
  output logic [1:0] tbl_mode_out,
  output logic nop_cycle_out
);

  idc_pkg::idc_state_e state_q, state_d;
  idc_pkg::idc_pend_e pend_q, pend_d;
  logic [7:0] pend_lo_q, pend_lo_d;
  logic pend_fast_q, pend_fast_d;
  idc_pkg::idc_ctl_s ctl_q, ctl_d;
  logic branch_ok;
  logic skip_ok;

  // first words that need a following operand word
  function automatic logic is_two_word(input logic [15:0] w);
    casez (w)
      `IDC_OP_CALL_W1, `IDC_OP_JUMP_W1, `IDC_OP_PTR_W1: is_two_word = 1'b1;
      default: is_two_word = 1'b0;
    endcase
  endfunction : is_two_word

  idc_cond_eval u_cond (
    .cond_in(instr_in[10:8]),
    .zero_in(zero_in),
    .carry_in(carry_in),
    .ovf_in(ovf_in),
    .neg_in(neg_in),
    .test_bit_in(test_bit_in),
    .skip_on_set_in(~instr_in[12]),
    .branch_ok_out(branch_ok),
    .skip_ok_out(skip_ok)
  );

  // next-state and next-control computation; control pulses default to zero
  always_comb begin
    ctl_d = '0;
    state_d = idc_pkg::ST_EXEC;
    pend_d = pend_q;
    pend_lo_d = pend_lo_q;
    pend_fast_d = pend_fast_q;
    case (state_q)
      idc_pkg::ST_EXEC: begin
        ctl_d.literal = instr_in[7:0];
        ctl_d.file_addr = instr_in[7:0];
        ctl_d.bit_pos = instr_in[11:9];
        ctl_d.access_sel = instr_in[8];
        casez (instr_in)
          `IDC_OP_BIT_CLEAR, `IDC_OP_BIT_SET, `IDC_OP_BIT_TOGGLE: begin
            if (instr_in[15:12] == `IDC_TOP_BIT_CLEAR) begin
              ctl_d.alu = idc_pkg::ALU_BCLR;
            end else if (instr_in[15:12] == `IDC_TOP_BIT_SET) begin
              ctl_d.alu = idc_pkg::ALU_BSET;
            end else begin
              ctl_d.alu = idc_pkg::ALU_BTOG;
            end
            ctl_d.file_write = 1'b1;
            // pins, not the output latch, feed the modify step
            ctl_d.use_pin_level = target_is_port_in;
            ctl_d.prescaler_clear = target_is_timer_zero_in
                && prescaler_on_timer_zero_in;
          end
          `IDC_OP_SKIP_CLEAR, `IDC_OP_SKIP_SET: begin
            if (skip_ok) begin
              ctl_d.skip = 1'b1;
              state_d = idc_pkg::ST_SKIP;
            end
          end
          `IDC_OP_COND_BRANCH: begin
            ctl_d.pc_offset = {{3{instr_in[7]}}, instr_in[7:0]};
            if (branch_ok) begin
              ctl_d.branch_taken = 1'b1;
              ctl_d.pc_load = 1'b1;
              ctl_d.pc_rel = 1'b1;
              state_d = idc_pkg::ST_FLUSH;
            end
          end
          `IDC_OP_CALL_W1: begin
            pend_d = idc_pkg::PEND_CALL;
            pend_lo_d = instr_in[7:0];
            pend_fast_d = instr_in[8];
            state_d = idc_pkg::ST_WORD2;
          end
          `IDC_OP_JUMP_W1: begin
            pend_d = idc_pkg::PEND_JUMP;
            pend_lo_d = instr_in[7:0];
            state_d = idc_pkg::ST_WORD2;
          end
          `IDC_OP_PTR_W1: begin
            pend_d = idc_pkg::PEND_PTR;
            pend_lo_d = instr_in[7:0];
            state_d = idc_pkg::ST_WORD2;
          end
          `IDC_OP_REL_JUMP, `IDC_OP_REL_CALL: begin
            ctl_d.pc_offset = instr_in[10:0];
            ctl_d.branch_taken = 1'b1;
            ctl_d.pc_load = 1'b1;
            ctl_d.pc_rel = 1'b1;
            ctl_d.stack_push = instr_in[11];
            state_d = idc_pkg::ST_FLUSH;
          end
          `IDC_OP_INT_RETURN, `IDC_OP_SUB_RETURN: begin
            ctl_d.stack_pop = 1'b1;
            ctl_d.pc_load = 1'b1;
            ctl_d.fast_restore = instr_in[0];
            ctl_d.gie_enable = ~instr_in[1];
            state_d = idc_pkg::ST_FLUSH;
          end
          `IDC_OP_LIT_RETURN: begin
            ctl_d.alu = idc_pkg::ALU_MOV;
            ctl_d.wreg_write = 1'b1;
            ctl_d.stack_pop = 1'b1;
            ctl_d.pc_load = 1'b1;
            state_d = idc_pkg::ST_FLUSH;
          end
          `IDC_OP_PUSH: ctl_d.stack_push = 1'b1;
          `IDC_OP_POP: ctl_d.stack_pop = 1'b1;
          `IDC_OP_STANDBY: ctl_d.standby = 1'b1;
          `IDC_OP_WDT_CLEAR: ctl_d.wdt_clear = 1'b1;
          `IDC_OP_SOFT_RESET: ctl_d.soft_reset = 1'b1;
          `IDC_OP_DEC_ADJUST: begin
            ctl_d.alu = idc_pkg::ALU_DEC_ADJ;
            ctl_d.wreg_write = 1'b1;
            ctl_d.flag_upd = `IDC_FLAGS_C;
          end
          `IDC_OP_ADD_LIT: begin
            ctl_d.alu = idc_pkg::ALU_ADD;
            ctl_d.wreg_write = 1'b1;
            ctl_d.flag_upd = `IDC_FLAGS_ARITH;
          end
          `IDC_OP_SUB_LIT: begin
            ctl_d.alu = idc_pkg::ALU_SUB;
            ctl_d.wreg_write = 1'b1;
            ctl_d.flag_upd = `IDC_FLAGS_ARITH;
          end
          `IDC_OP_AND_LIT, `IDC_OP_OR_LIT, `IDC_OP_XOR_LIT: begin
            if (instr_in[9:8] == 2'h3) begin
              ctl_d.alu = idc_pkg::ALU_AND;
            end else if (instr_in[9:8] == 2'h1) begin
              ctl_d.alu = idc_pkg::ALU_OR;
            end else begin
              ctl_d.alu = idc_pkg::ALU_XOR;
            end
            ctl_d.wreg_write = 1'b1;
            ctl_d.flag_upd = `IDC_FLAGS_ZN;
          end
          // product goes to the product pair, so no working register write
          `IDC_OP_MUL_LIT: ctl_d.alu = idc_pkg::ALU_MUL;
          `IDC_OP_MOV_LIT: begin
            ctl_d.alu = idc_pkg::ALU_MOV;
            ctl_d.wreg_write = 1'b1;
          end
          `IDC_OP_BANK_LIT: begin
            ctl_d.literal = {4'h0, instr_in[3:0]};
            ctl_d.bank_load = 1'b1;
          end
          `IDC_OP_TBL_READ, `IDC_OP_TBL_WRITE: begin
            ctl_d.tbl_read = ~instr_in[2];
            ctl_d.tbl_write = instr_in[2];
            ctl_d.tbl_mode = instr_in[1:0];
            state_d = idc_pkg::ST_FLUSH;
          end
          // stray second words and unassigned codes fall here
          default: ctl_d.nop_cycle = 1'b1;
        endcase
      end
      idc_pkg::ST_WORD2: begin
        // a word without the prefix cannot finish the pair; it is dropped
        if (instr_in[15:12] == `IDC_WORD2_PREFIX) begin
          case (pend_q)
            idc_pkg::PEND_CALL, idc_pkg::PEND_JUMP: begin
              ctl_d.pc_target = {instr_in[11:0], pend_lo_q};
              ctl_d.pc_load = 1'b1;
              ctl_d.stack_push = (pend_q == idc_pkg::PEND_CALL);
              ctl_d.fast_save = (pend_q == idc_pkg::PEND_CALL) && pend_fast_q;
            end
            idc_pkg::PEND_PTR: begin
              ctl_d.ptr_load = 1'b1;
              ctl_d.ptr_sel = pend_lo_q[5:4];
              ctl_d.ptr_value = {pend_lo_q[3:0], instr_in[7:0]};
            end
            default: ctl_d.nop_cycle = 1'b1;
          endcase
        end else begin
          ctl_d.nop_cycle = 1'b1;
        end
        pend_d = idc_pkg::PEND_NONE;
      end
      idc_pkg::ST_FLUSH: ctl_d.nop_cycle = 1'b1;
      idc_pkg::ST_SKIP: begin
        ctl_d.nop_cycle = 1'b1;
        // skipping a pair also discards its operand word
        if (is_two_word(instr_in)) begin
          state_d = idc_pkg::ST_FLUSH;
        end
      end
      default: state_d = idc_pkg::ST_EXEC;
    endcase
  end

  // registers; reset wins, otherwise clock enable low freezes every one of them
  always_ff @(posedge sys_clk_in) begin
    if (!rst_n_in) begin
      state_q <= idc_pkg::ST_EXEC;
      pend_q <= idc_pkg::PEND_NONE;
      pend_lo_q <= 8'h00;
      pend_fast_q <= 1'b0;
      ctl_q <= '0;
    end else if (clk_en_in) begin
      state_q <= state_d;
      pend_q <= pend_d;
      pend_lo_q <= pend_lo_d;
      pend_fast_q <= pend_fast_d;
      ctl_q <= ctl_d;
    end
  end

  // outputs taken straight from the control register
  assign alu_op_out = ctl_q.alu;
  assign literal_out = ctl_q.literal;
  assign wreg_write_out = ctl_q.wreg_write;
  assign flag_upd_out = ctl_q.flag_upd;
  assign file_addr_out = ctl_q.file_addr;
  assign bit_pos_out = ctl_q.bit_pos;
  assign access_sel_out = ctl_q.access_sel;
  assign file_write_out = ctl_q.file_write;
  assign use_pin_level_out = ctl_q.use_pin_level;
  assign prescaler_clear_out = ctl_q.prescaler_clear;
  assign skip_out = ctl_q.skip;
  assign branch_taken_out = ctl_q.branch_taken;
  assign pc_load_out = ctl_q.pc_load;
  assign pc_rel_out = ctl_q.pc_rel;
  assign pc_target_out = ctl_q.pc_target;
  assign pc_offset_out = ctl_q.pc_offset;
  assign stack_push_out = ctl_q.stack_push;
  assign stack_pop_out = ctl_q.stack_pop;
  assign fast_save_out = ctl_q.fast_save;
  assign fast_restore_out = ctl_q.fast_restore;
  assign gie_enable_out = ctl_q.gie_enable;
  assign standby_out = ctl_q.standby;
  assign wdt_clear_out = ctl_q.wdt_clear;
  assign soft_reset_out = ctl_q.soft_reset;
  assign bank_load_out = ctl_q.bank_load;
  assign ptr_load_out = ctl_q.ptr_load;
  assign ptr_sel_out = ctl_q.ptr_sel;
  assign ptr_value_out = ctl_q.ptr_value;
  assign tbl_read_out = ctl_q.tbl_read;
  assign tbl_write_out = ctl_q.tbl_write;
  assign tbl_mode_out = ctl_q.tbl_mode;
  assign nop_cycle_out = ctl_q.nop_cycle;

  // checks on decoded behaviour
  default clocking cb @(posedge sys_clk_in); endclocking
  default disable iff (!rst_n_in);

  logic exec_en;
  assign exec_en = clk_en_in && (state_q == idc_pkg::ST_EXEC);

  AST_BIT_WRITE: assert property (
    exec_en && instr_in[15:12] == 4'h9 |=> file_write_out && alu_op_out == 4'h8
      && flag_upd_out == 5'h00 && !nop_cycle_out)
    else $error("bit clear not issued in one cycle");

  AST_SKIP_PAIR: assert property (
    exec_en && instr_in[15:13] == 3'b101 && skip_ok ##1 clk_en_in
      && is_two_word(instr_in) ##1 clk_en_in |=> nop_cycle_out && $past(nop_cycle_out))
    else $error("skip over a pair did not take three cycles");

  AST_BRANCH_IDLE: assert property (
    exec_en && instr_in[15:11] == 5'b11100 && !branch_ok
      |=> !pc_load_out && !branch_taken_out)
    else $error("untaken branch loaded the program counter");

  AST_CALL_DONE: assert property (
    exec_en && instr_in[15:9] == 7'b1110110 ##1 clk_en_in && instr_in[15:12] == 4'hf
      |=> pc_load_out && stack_push_out && pc_target_out[7:0] == pend_lo_q)
    else $error("call second word not consumed");

  AST_RETURN_FLUSH: assert property (
    exec_en && instr_in[15:1] == 15'h0009 ##1 clk_en_in
      |-> stack_pop_out && pc_load_out ##1 nop_cycle_out)
    else $error("return did not pop and flush");

  AST_ADD_FLAGS: assert property (
    exec_en && instr_in[15:8] == 8'h0f |=> flag_upd_out == 5'h1f && wreg_write_out)
    else $error("literal add flags wrong");

  AST_LOGIC_FLAGS: assert property (
    exec_en && instr_in[15:10] == 6'b000010 && instr_in[9:8] != 2'h0
      |=> flag_upd_out == 5'h14 && !stack_pop_out)
    else $error("literal logic flags wrong");

  AST_PIN_SOURCE: assert property (
    exec_en && instr_in[15:12] == 4'h7 && target_is_port_in |=> use_pin_level_out)
    else $error("port modify did not use pin level");

  AST_PRESCALE: assert property (
    exec_en && instr_in[15:12] == 4'h8 && target_is_timer_zero_in
      && prescaler_on_timer_zero_in |=> prescaler_clear_out)
    else $error("timer zero bit write left prescaler");

  AST_STRAY_WORD: assert property (
    exec_en && instr_in[15:12] == 4'hf |=> nop_cycle_out && !pc_load_out
      && !wreg_write_out && state_q == idc_pkg::ST_EXEC)
    else $error("stray second word not a nop");

endmodule : idc_decoder

// *** hdl/idc_defs.svh ***
`ifndef IDC_DEFS_SVH
`define IDC_DEFS_SVH

// opcode patterns, matched with casez
`define IDC_OP_BIT_CLEAR 16'b1001_????_????_????
`define IDC_OP_BIT_SET 16'b1000_????_????_????
`define IDC_OP_BIT_TOGGLE 16'b0111_????_????_????
`define IDC_OP_SKIP_CLEAR 16'b1011_????_????_????
`define IDC_OP_SKIP_SET 16'b1010_????_????_????
`define IDC_OP_COND_BRANCH 16'b1110_0???_????_????
`define IDC_OP_CALL_W1 16'b1110_110?_????_????
`define IDC_OP_JUMP_W1 16'b1110_1111_????_????
`define IDC_OP_PTR_W1 16'b1110_1110_00??_????
`define IDC_OP_REL_JUMP 16'b1101_0???_????_????
`define IDC_OP_REL_CALL 16'b1101_1???_????_????
`define IDC_OP_INT_RETURN 16'b0000_0000_0001_000?
`define IDC_OP_SUB_RETURN 16'b0000_0000_0001_001?
`define IDC_OP_LIT_RETURN 16'b0000_1100_????_????
`define IDC_OP_PUSH 16'h0005
`define IDC_OP_POP 16'h0006
`define IDC_OP_STANDBY 16'h0003
`define IDC_OP_WDT_CLEAR 16'h0004
`define IDC_OP_DEC_ADJUST 16'h0007
`define IDC_OP_SOFT_RESET 16'h00ff
`define IDC_OP_ADD_LIT 16'b0000_1111_????_????
`define IDC_OP_SUB_LIT 16'b0000_1000_????_????
`define IDC_OP_AND_LIT 16'b0000_1011_????_????
`define IDC_OP_OR_LIT 16'b0000_1001_????_????
`define IDC_OP_XOR_LIT 16'b0000_1010_????_????
`define IDC_OP_MUL_LIT 16'b0000_1101_????_????
`define IDC_OP_MOV_LIT 16'b0000_1110_????_????
`define IDC_OP_BANK_LIT 16'b0000_0001_0000_????
`define IDC_OP_TBL_READ 16'b0000_0000_0000_10??
`define IDC_OP_TBL_WRITE 16'b0000_0000_0000_11??
`define IDC_WORD2_PREFIX 4'hf
`define IDC_TOP_BIT_CLEAR 4'h9
`define IDC_TOP_BIT_SET 4'h8

// status flag update masks, bit order {n, ov, z, dc, c}
`define IDC_FLAGS_NONE 5'h00
`define IDC_FLAGS_ARITH 5'h1f
`define IDC_FLAGS_ZN 5'h14
`define IDC_FLAGS_C 5'h01

// condition flag selectors, cond[2:1]
`define IDC_CC_ZERO 2'h0
`define IDC_CC_CARRY 2'h1
`define IDC_CC_OVF 2'h2
`define IDC_CC_NEG 2'h3

`endif

// *** hdl/idc_pkg.sv ***
package idc_pkg;

  typedef enum logic [3:0] {
    ST_EXEC = 4'b0001,
    ST_WORD2 = 4'b0010,
    ST_FLUSH = 4'b0100,
    ST_SKIP = 4'b1000
  } idc_state_e;

  typedef enum logic [1:0] {
    PEND_NONE = 2'h0,
    PEND_JUMP = 2'h1,
    PEND_CALL = 2'h2,
    PEND_PTR = 2'h3
  } idc_pend_e;

  typedef enum logic [3:0] {
    ALU_NONE = 4'h0,
    ALU_ADD = 4'h1,
    ALU_SUB = 4'h2,
    ALU_AND = 4'h3,
    ALU_OR = 4'h4,
    ALU_XOR = 4'h5,
    ALU_MUL = 4'h6,
    ALU_MOV = 4'h7,
    ALU_BCLR = 4'h8,
    ALU_BSET = 4'h9,
    ALU_BTOG = 4'ha,
    ALU_DEC_ADJ = 4'hb
  } idc_alu_e;

  typedef struct packed {
    idc_alu_e alu;
    logic [7:0] literal;
    logic wreg_write;
    logic [4:0] flag_upd;
    logic [7:0] file_addr;
    logic [2:0] bit_pos;
    logic access_sel;
    logic file_write;
    logic use_pin_level;
    logic prescaler_clear;
    logic skip;
    logic branch_taken;
    logic pc_load;
    logic pc_rel;
    logic [19:0] pc_target;
    logic [10:0] pc_offset;
    logic stack_push;
    logic stack_pop;
    logic fast_save;
    logic fast_restore;
    logic gie_enable;
    logic standby;
    logic wdt_clear;
    logic soft_reset;
    logic bank_load;
    logic ptr_load;
    logic [1:0] ptr_sel;
    logic [11:0] ptr_value;
    logic tbl_read;
    logic tbl_write;
    logic [1:0] tbl_mode;
    logic nop_cycle;
  } idc_ctl_s;

endpackage : idc_pkg

// *** sim/idc_prog_mem.sv ***
`timescale 1ns/1ns

// program memory model: streams words in program order, one per enabled edge
module idc_prog_mem (
  input wire logic sys_clk_in,
  input wire logic restart_in,
  input wire logic clk_en_in,
  output logic [15:0] instr_out
);
  logic [15:0] mem [0:7];
  logic [2:0] addr_q;
  logic [2:0] addr_d;

  // fetch address: restart wins, a frozen core fetches nothing new
  always_comb begin
    addr_d = addr_q;
    if (restart_in) begin
      addr_d = 3'h0;
    end else if (clk_en_in) begin
      addr_d = addr_q + 3'h1;
    end
  end

  always_ff @(posedge sys_clk_in) begin
    addr_q <= addr_d;
  end

  // words past the loaded program read as zero, a plain nop, so runs drain cleanly
  assign instr_out = mem[addr_q];
endmodule : idc_prog_mem

// *** sim/tb_mcu_instr_decode_bit_ctrl_lit.sv ***
`timescale 1ns/1ns

module tb_mcu_instr_decode_bit_ctrl_lit;
  localparam int W = $bits(idc_pkg::idc_ctl_s) - 5;
  logic sys_clk_in = 1'b0;
  logic rst_n_in = 1'b0;
  logic clk_en_in = 1'b1;
  logic restart = 1'b1;
  logic tbit = 1'b0;
  logic [3:0] fl = 4'h0; // {neg, ovf, zero, carry}
  logic [2:0] tg = 3'h0; // {prescaler on timer, timer zero, port}
  logic [15:0] instr;
  wire [3:0] alu;
  wire idc_pkg::idc_ctl_s o;
  wire [7:0] flow = {o.pc_load, o.pc_rel, o.stack_push, o.stack_pop, o.fast_save,
    o.fast_restore, o.gie_enable, o.nop_cycle};
  idc_pkg::idc_ctl_s e;
  idc_pkg::idc_ctl_s add_e;
  integer seed = 24408;
  int bad_count = 0;
  int checks = 0;
  int i;
  logic [15:0] w;
  logic [23:0] t;
  logic sk;
  logic [23:0] lt [7] = '{24'h0f111f, 24'h08211f, 24'h0b3114, 24'h094114, 24'h0a5114,
    24'h0d6000, 24'h0e7100};
  logic [7:0] bt [3] = '{8'h98, 8'h89, 8'h7a};
  logic [15:0] p1 [5] = '{16'hed34, 16'hec5a, 16'hef56, 16'hee2a, 16'hed34};
  logic [15:0] p2 [5] = '{16'hf012, 16'hfabc, 16'hf789, 16'hf0bc, 16'h0f3c};
  logic [7:0] pf [5] = '{8'ha8, 8'ha0, 8'h80, 8'h00, 8'h01};
  logic [15:0] fw [15] = '{16'h0010, 16'h0011, 16'h0012, 16'h0013, 16'h0c5a, 16'hd3a5,
    16'hdc5a, 16'h0008, 16'h0009, 16'h000a, 16'h000b, 16'h000c, 16'h000d, 16'h000e, 16'h000f};
  logic [15:0] sw [10] = '{16'h0003, 16'h0004, 16'h00ff, 16'h0005, 16'h0006, 16'h0107,
    16'hf5a3, 16'h0002, 16'h0000, 16'h0007};

`define CHK(nm, xp, got) \
  begin checks++; if ((got) !== (xp)) begin bad_count++; \
  $display("MISMATCH %s expected %h seen %h", nm, xp, got); end end

  always #20 sys_clk_in = ~sys_clk_in;

  idc_prog_mem idc_prog_mem_i (.sys_clk_in(sys_clk_in), .restart_in(restart),
    .clk_en_in(clk_en_in), .instr_out(instr));

  idc_decoder idc_decoder_i (
    .sys_clk_in(sys_clk_in), .rst_n_in(rst_n_in), .clk_en_in(clk_en_in), .instr_in(instr),
    .carry_in(fl[0]), .zero_in(fl[1]), .ovf_in(fl[2]), .neg_in(fl[3]), .test_bit_in(tbit),
    .target_is_port_in(tg[0]), .target_is_timer_zero_in(tg[1]),
    .prescaler_on_timer_zero_in(tg[2]), .alu_op_out(alu), .literal_out(o.literal),
    .wreg_write_out(o.wreg_write), .flag_upd_out(o.flag_upd), .file_addr_out(o.file_addr),
    .bit_pos_out(o.bit_pos), .access_sel_out(o.access_sel), .file_write_out(o.file_write),
    .use_pin_level_out(o.use_pin_level), .prescaler_clear_out(o.prescaler_clear),
    .skip_out(o.skip), .branch_taken_out(o.branch_taken), .pc_load_out(o.pc_load),
    .pc_rel_out(o.pc_rel), .pc_target_out(o.pc_target), .pc_offset_out(o.pc_offset),
    .stack_push_out(o.stack_push), .stack_pop_out(o.stack_pop), .fast_save_out(o.fast_save),
    .fast_restore_out(o.fast_restore), .gie_enable_out(o.gie_enable),
    .standby_out(o.standby), .wdt_clear_out(o.wdt_clear), .soft_reset_out(o.soft_reset),
    .bank_load_out(o.bank_load), .ptr_load_out(o.ptr_load), .ptr_sel_out(o.ptr_sel),
    .ptr_value_out(o.ptr_value), .tbl_read_out(o.tbl_read), .tbl_write_out(o.tbl_write),
    .tbl_mode_out(o.tbl_mode), .nop_cycle_out(o.nop_cycle));

  // expected control word for a word decoded in the execute state
  function automatic idc_pkg::idc_ctl_s ex(input logic [15:0] w);
    ex = '0;
    ex.literal = w[7:0];
    ex.file_addr = w[7:0];
    ex.bit_pos = w[11:9];
    ex.access_sel = w[8];
    casez (w)
      16'h0003: ex.standby = 1'b1;
      16'h0004: ex.wdt_clear = 1'b1;
      16'h00ff: ex.soft_reset = 1'b1;
      16'h0005: ex.stack_push = 1'b1;
      16'h0006: ex.stack_pop = 1'b1;
      // decimal adjust rewrites the working register and only touches carry
      16'h0007: begin
        ex.wreg_write = 1'b1;
        ex.flag_upd = 5'h01;
      end
      16'b0000_0001_0000_????: ex.bank_load = 1'b1;
      16'b1111_????_????_????, 16'h0000, 16'h0002: ex.nop_cycle = 1'b1;
      default: ex.nop_cycle = 1'b0;
    endcase
  endfunction : ex

  // branch condition: code bits 2:1 pick the flag, bit 0 inverts it
  function automatic logic brk(input logic [2:0] c, input logic [3:0] f);
    logic [3:0] m;
    m = {f[3], f[2], f[0], f[1]};
    return m[c[2:1]] ^ c[0];
  endfunction : brk

  // expected flow bits for returns and relative transfers
  function automatic logic [7:0] flw(input logic [15:0] w);
    casez (w)
      16'b0000_0000_0001_00??: flw = {4'h9, 1'b0, w[0], ~w[1], 1'b0};
      16'b0000_1100_????_????: flw = 8'h90;
      16'b1101_0???_????_????: flw = 8'hc0;
      16'b1101_1???_????_????: flw = 8'he0;
      default: flw = 8'h00;
    endcase
  endfunction : flw

  // reset the decoder and point program memory at a fresh program
  task automatic go(input logic [15:0] a, b, c, d);
    rst_n_in = 1'b0;
    restart = 1'b1;
    idc_prog_mem_i.mem = '{a, b, c, d, 16'h0, 16'h0, 16'h0, 16'h0};
    @(posedge sys_clk_in);
    #1;
    rst_n_in = 1'b1;
    restart = 1'b0;
    `CHK("reset", '0, {alu, o[W:0]})
  endtask : go

  // one enabled edge, then the whole control word; outputs settle 1 ns after
  task automatic step(input idc_pkg::idc_ctl_s x, input logic [3:0] xa);
    @(posedge sys_clk_in);
    #1;
    `CHK("ctl", x[W:0], o[W:0])
    `CHK("alu", xa, alu)
  endtask : step

  task automatic fstep(input logic [7:0] f);
    @(posedge sys_clk_in);
    #1;
    `CHK("flow", f, flow)
  endtask : fstep

  task automatic stop_test();
    $display("checks %0d mismatches %0d", checks, bad_count);
    if (bad_count == 0 && checks > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : stop_test

  // the sequence needs under a thousand cycles, so 5000 means a hang
  initial begin
    #200000;
    bad_count++;
    stop_test();
  end

  initial begin
    idc_prog_mem_i.mem = '{default: 16'h0};
    add_e = ex(16'h0f3c);
    add_e.wreg_write = 1'b1;
    add_e.flag_upd = 5'h1f;
    repeat (10) @(posedge sys_clk_in);
    #1;
    rst_n_in = 1'b1;
    // literal table: opcode byte, alu code, write enable, flag mask
    for (i = 0; i < 7; i++) begin
      t = lt[i];
      w = {t[23:16], 8'($random(seed))};
      go(w, 16'h0, 16'h0, 16'h0);
      e = ex(w);
      e.wreg_write = t[8];
      e.flag_upd = t[4:0];
      step(e, t[15:12]);
    end
    $display("test literal done");
    for (i = 0; i < 6; i++) begin
      t = {16'h0, bt[i % 3]};
      w = {t[7:4], 12'($random(seed))};
      tg = 3'($random(seed));
      go(w, 16'h0f3c, 16'h0, 16'h0);
      e = ex(w);
      e.file_write = 1'b1;
      e.use_pin_level = tg[0];
      e.prescaler_clear = tg[1] & tg[2];
      step(e, t[3:0]);
      step(add_e, 4'h1);
    end
    tg = 3'h0;
    $display("test bit ops done");
    for (i = 0; i < 16; i++) begin
      w = {5'b11100, 3'(i), 8'($random(seed))};
      fl = 4'($random(seed));
      sk = brk(w[10:8], fl);
      go(w, 16'h0f3c, 16'h0, 16'h0);
      e = ex(w);
      e.branch_taken = sk;
      e.pc_load = sk;
      e.pc_rel = sk;
      e.pc_offset = {{3{w[7]}}, w[7:0]};
      step(e, 4'h0);
      if (sk) fstep(8'h01);
      else step(add_e, 4'h1);
    end
    $display("test branch done");
    // a skip over a call pair must swallow both words
    for (i = 0; i < 8; i++) begin
      w = {3'b101, 1'(i), 12'($random(seed))};
      tbit = 1'($random(seed));
      sk = tbit ^ w[12];
      go(w, 16'hed12, 16'hf345, 16'h0f3c);
      e = ex(w);
      e.skip = sk;
      step(e, 4'h0);
      fstep({7'h0, sk});
      fstep(sk ? 8'h01 : 8'ha8);
      if (!sk) `CHK("target", 20'h34512, o.pc_target)
      step(add_e, 4'h1);
    end
    $display("test skip done");
    for (i = 0; i < 5; i++) begin
      go(p1[i], p2[i], 16'h0f3c, 16'h0);
      fstep(8'h00);
      fstep(pf[i]);
      if (pf[i][7]) `CHK("target", {p2[i][11:0], p1[i][7:0]}, o.pc_target)
      `CHK("ptr", (i == 3) ? 15'h6abc : 15'h0, {o.ptr_load, o.ptr_sel, o.ptr_value})
      step(add_e, 4'h1);
    end
    $display("test pairs done");
    for (i = 0; i < 15; i++) begin
      w = fw[i];
      go(w, 16'h0f3c, 16'h0, 16'h0);
      fstep(flw(w));
      t = {20'h0, (w[15:3] == 13'h1) ? {~w[2], w[2], w[1:0]} : 4'h0};
      `CHK("table", t[3:0], {o.tbl_read, o.tbl_write, o.tbl_mode})
      `CHK("wreg", {w[15:8] == 8'h0c, w[7:0], 5'h0}, {o.wreg_write, o.literal, o.flag_upd})
      if (w[15:12] == 4'hd) `CHK("offset", w[10:0], o.pc_offset)
      fstep(8'h01);
    end
    $display("test flow done");
    for (i = 0; i < 10; i++) begin
      go(sw[i], 16'h0f3c, 16'h0, 16'h0);
      step(ex(sw[i]), (sw[i] == 16'h0007) ? 4'hb : 4'h0);
      step(add_e, 4'h1);
    end
    $display("test single words done");
    // a frozen core keeps its outputs standing
    go(16'h0f3c, 16'h0, 16'h0, 16'h0);
    step(add_e, 4'h1);
    clk_en_in = 1'b0;
    repeat (3) @(posedge sys_clk_in);
    #1;
    `CHK("hold", 4'h1, alu)
    clk_en_in = 1'b1;
    $display("test hold done");
    stop_test();
  end
endmodule : tb_mcu_instr_decode_bit_ctrl_lit
